// ===== src/lpwp_pkg.sv
// Purpose: Shared constants and types of the low power mode and write protect register bank.
// Assumes: APB slave with 32-bit data, one aligned word per register, 40 MHz system clock.
// Notes: Offsets, three field positions and five reset values live here; other field slices and resets are written as literals in the modules.
package lpwp_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFS_STANDBY = 8'h00;
    localparam logic [7:0] OFS_MSTOP_A = 8'h04;
    localparam logic [7:0] OFS_MSTOP_B = 8'h08;
    localparam logic [7:0] OFS_MSTOP_C = 8'h0c;
    localparam logic [7:0] OFS_MSTOP_D = 8'h10;
    localparam logic [7:0] OFS_OP_POWER = 8'h14;
    localparam logic [7:0] OFS_SUB_POWER = 8'h18;
    localparam logic [7:0] OFS_OSC_WAIT = 8'h1c;
    localparam logic [7:0] OFS_RET_CLOCK = 8'h20;
    localparam logic [7:0] OFS_PROTECT = 8'h24;
    localparam logic [7:0] OFS_SW_RESET = 8'h28;
    localparam logic [7:0] OFS_STATUS = 8'h2c;

    // Field positions.
    localparam int POS_SELECT = 15;
    localparam int POS_OUT_EN = 14;
    localparam int POS_DEEP_SLEEP = 31;

    // Reset values.
    localparam logic [31:0] RST_MSTOP = 32'hffff_ffff;
    localparam logic [2:0] RST_OP_MODE = 3'h0;
    localparam logic [4:0] RST_OSC_WAIT = 5'h00;
    localparam logic [2:0] RST_RET_CLOCK = 3'h0;
    localparam logic [3:0] RST_PROTECT = 4'h0;

    // Supported codes.
    localparam logic [2:0] OPM_HIGH = 3'h0;
    localparam logic [2:0] OPM_MIDDLE = 3'h2;
    localparam logic [4:0] OSC_WAIT_LAST = 5'h07;
    localparam logic [2:0] RCK_LOW_OSC = 3'h0;
    localparam logic [2:0] RCK_HIGH_OSC = 3'h1;
    localparam logic [2:0] RCK_MAIN_OSC = 3'h2;

    // Effective operating speed reported to the clock logic.
    localparam logic [1:0] SPEED_HIGH = 2'h0;
    localparam logic [1:0] SPEED_MIDDLE = 2'h1;
    localparam logic [1:0] SPEED_LOW = 2'h2;

    // Oscillator stabilisation waits in oscillator cycles.
    localparam int WAIT_CODE0 = 2;
    localparam int WAIT_CODE1 = 1024;
    localparam int WAIT_CODE2 = 2048;
    localparam int WAIT_CODE3 = 4096;
    localparam int WAIT_CODE4 = 8192;
    localparam int WAIT_CODE5 = 16384;
    localparam int WAIT_CODE6 = 32768;
    localparam int WAIT_CODE7 = 65536;
    localparam int WAIT_WIDTH = 17;

    // Low power sequencer states, one-hot.
    typedef enum logic [4:0] {
        LPWP_RUN = 5'b00001,
        LPWP_SLEEP = 5'b00010,
        LPWP_DEEP = 5'b00100,
        LPWP_STANDBY = 5'b01000,
        LPWP_OSC_WAIT = 5'b10000
    } lpwp_state_t;

endpackage

// ===== src/lpwp_wait_timer.sv
// Purpose: Down counter that times the oscillator stabilisation wait.
// Assumes: Load and count on the system clock; the count is at least one.
// Notes: The done pulse comes exactly count cycles after the load edge.
`timescale 1ns/1ps
module lpwp_wait_timer #(
    parameter int WIDTH = 17
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_in,
    // Control.
    input wire logic load_in,
    input wire logic [WIDTH-1:0] count_in,
    // Status.
    output logic busy_out,
    output logic done_out
);
    // A counter narrower than two bits is refused.
    if (WIDTH < 2) begin : g_check
        $error("lpwp_wait_timer: WIDTH must be at least 2.");
    end

    logic [WIDTH-1:0] cnt_r; // Remaining cycles.
    logic [WIDTH-1:0] cnt_nxt;
    logic busy_r; // Counting.
    logic busy_nxt;
    logic done_r; // One-cycle end marker.
    logic done_nxt;

    // Next-state logic: a load restarts the count even while busy.
    always_comb begin
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        if (load_in) begin
            cnt_nxt = count_in;
            busy_nxt = 1'b1;
        end else if (busy_r) begin
            if (cnt_r <= WIDTH'(1)) begin
                // Last cycle of the wait.
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
                cnt_nxt = '0;
            end else begin
                cnt_nxt = cnt_r - WIDTH'(1);
            end
        end
    end

    // State registers.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy_out = busy_r;
    assign done_out = done_r;
endmodule

// ===== src/lpwp_regs.sv
// Purpose: Low power mode control and register write protection, reached over APB.
// Assumes: Wait and wake requests come from core logic on the same clock.
// Notes: Zero wait state slave; unmapped addresses answer with pslverr.
`timescale 1ns/1ps
module lpwp_regs
    import lpwp_pkg::*;
#(
    // Waits above 4096 cycles, shortenable for simulation.
    parameter int WAIT_8192 = WAIT_CODE4,
    parameter int WAIT_16384 = WAIT_CODE5,
    parameter int WAIT_32768 = WAIT_CODE6,
    parameter int WAIT_65536 = WAIT_CODE7
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_in,
    // APB slave.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Core events.
    input wire logic wait_exec_in,
    input wire logic wake_in,
    // Low power status.
    output logic cpu_stop_out,
    output logic sleep_out,
    output logic deep_sleep_out,
    output logic standby_out,
    output logic bus_float_out,
    output logic bus_hold_out,
    output logic [1:0] speed_out,
    output logic [2:0] return_clock_out,
    // Module stop lines.
    output logic [31:0] module_stop_a_out,
    output logic [31:0] module_stop_b_out,
    output logic [31:0] module_stop_c_out,
    output logic [31:0] module_stop_d_out,
    // Write permission for registers held elsewhere, and the software reset pulse.
    output logic clock_regs_write_ok_out,
    output logic mode_regs_write_ok_out,
    output logic low_power_timer_write_ok_out,
    output logic voltage_detect_write_ok_out,
    output logic software_reset_out
);
    // The timer must hold the longest wait.
    if (WAIT_65536 < 1 || WAIT_65536 >= (1 << WAIT_WIDTH) || WAIT_8192 < 1
            || WAIT_16384 < 1 || WAIT_32768 < 1) begin : g_check
        $error("lpwp_regs: wait parameters out of range.");
    end

    // Register state.
    logic select_r; // Wait enters software standby when set.
    logic select_nxt;
    logic out_en_r; // Bus outputs hold in standby when set.
    logic out_en_nxt;
    logic [31:0] mstop_a_r;
    logic [31:0] mstop_a_nxt;
    logic [31:0] mstop_b_r;
    logic [31:0] mstop_b_nxt;
    logic [31:0] mstop_c_r; // Top bit is deep sleep enable.
    logic [31:0] mstop_c_nxt;
    logic [31:0] mstop_d_r;
    logic [31:0] mstop_d_nxt;
    logic [2:0] op_mode_r;
    logic [2:0] op_mode_nxt;
    logic sub_mode_r;
    logic sub_mode_nxt;
    logic [4:0] osc_wait_r;
    logic [4:0] osc_wait_nxt;
    logic [2:0] ret_clock_r;
    logic [2:0] ret_clock_nxt;
    logic [3:0] protect_r;
    logic [3:0] protect_nxt;
    logic swrst_r;
    logic swrst_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    // Sequencer state.
    lpwp_state_t state_r;
    lpwp_state_t state_nxt;
    logic float_r;
    logic float_nxt;
    logic hold_r;
    logic hold_nxt;
    logic [1:0] speed_r;
    logic [1:0] speed_nxt;
    logic timer_load;
    logic [WAIT_WIDTH-1:0] timer_count;
    logic timer_busy;
    logic timer_done;

    // Bus decode.
    logic access; // Access phase of any transfer.
    logic wr_cycle; // Write takes effect this edge.
    logic mapped; // Address hits a register.
    logic mode_ok; // Protect bit 1 permits writes.

    assign access = psel_in && penable_in;
    assign wr_cycle = access && pwrite_in && mapped;
    assign mode_ok = protect_r[1];

    // Address decode; only aligned words of the map respond.
    always_comb begin
        case (paddr_in)
            OFS_STANDBY, OFS_MSTOP_A, OFS_MSTOP_B, OFS_MSTOP_C, OFS_MSTOP_D,
            OFS_OP_POWER, OFS_SUB_POWER, OFS_OSC_WAIT, OFS_RET_CLOCK,
            OFS_PROTECT, OFS_SW_RESET, OFS_STATUS: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Oscillator wait code to stabilisation cycles, counted on the system clock.
    function automatic logic [WAIT_WIDTH-1:0] wait_cycles(input logic [4:0] code);
        int n;
        case (code)
            5'h00: n = WAIT_CODE0;
            5'h01: n = WAIT_CODE1;
            5'h02: n = WAIT_CODE2;
            5'h03: n = WAIT_CODE3;
            5'h04: n = WAIT_8192;
            5'h05: n = WAIT_16384;
            5'h06: n = WAIT_32768;
            default: n = WAIT_65536;
        endcase
        return n[WAIT_WIDTH-1:0];
    endfunction

    // Register writes. A refused write keeps every bit and raises no error,
    // so software that forgets the protect bit sees only a missing effect.
    always_comb begin
        select_nxt = select_r;
        out_en_nxt = out_en_r;
        mstop_a_nxt = mstop_a_r;
        mstop_b_nxt = mstop_b_r;
        mstop_c_nxt = mstop_c_r;
        mstop_d_nxt = mstop_d_r;
        op_mode_nxt = op_mode_r;
        sub_mode_nxt = sub_mode_r;
        osc_wait_nxt = osc_wait_r;
        ret_clock_nxt = ret_clock_r;
        protect_nxt = protect_r;
        swrst_nxt = 1'b0;
        if (wr_cycle) begin
            case (paddr_in)
                OFS_STANDBY: begin
                    if (mode_ok) begin
                        select_nxt = pwdata_in[POS_SELECT];
                        out_en_nxt = pwdata_in[POS_OUT_EN];
                    end
                end
                OFS_MSTOP_A: begin
                    if (mode_ok) begin
                        mstop_a_nxt = pwdata_in;
                    end
                end
                OFS_MSTOP_B: begin
                    if (mode_ok) begin
                        mstop_b_nxt = pwdata_in;
                    end
                end
                OFS_MSTOP_C: begin
                    if (mode_ok) begin
                        mstop_c_nxt = pwdata_in;
                    end
                end
                OFS_MSTOP_D: begin
                    if (mode_ok) begin
                        mstop_d_nxt = pwdata_in;
                    end
                end
                OFS_OP_POWER: begin
                    // Unsupported mode codes are dropped rather than stored.
                    if (mode_ok && (pwdata_in[2:0] == OPM_HIGH
                            || pwdata_in[2:0] == OPM_MIDDLE)) begin
                        op_mode_nxt = pwdata_in[2:0];
                    end
                end
                OFS_SUB_POWER: begin
                    if (mode_ok) begin
                        sub_mode_nxt = pwdata_in[0];
                    end
                end
                OFS_OSC_WAIT: begin
                    // Codes above the last supported one are unavailable.
                    if (mode_ok && pwdata_in[4:0] <= OSC_WAIT_LAST) begin
                        osc_wait_nxt = pwdata_in[4:0];
                    end
                end
                OFS_RET_CLOCK: begin
                    if (mode_ok && pwdata_in[2:0] <= RCK_MAIN_OSC) begin
                        ret_clock_nxt = pwdata_in[2:0];
                    end
                end
                OFS_PROTECT: begin
                    // The protect register itself is always writable.
                    protect_nxt = pwdata_in[3:0];
                end
                OFS_SW_RESET: begin
                    swrst_nxt = mode_ok;
                end
                default: begin
                    // Status is read only; writes to it are ignored.
                end
            endcase
        end
    end

    // Read data, captured at the setup edge so it stands through the access.
    always_comb begin
        rdata_nxt = rdata_r;
        if (psel_in && !penable_in && !pwrite_in) begin
            rdata_nxt = 32'h0000_0000;
            case (paddr_in)
                OFS_STANDBY: begin
                    rdata_nxt[POS_SELECT] = select_r;
                    rdata_nxt[POS_OUT_EN] = out_en_r;
                end
                OFS_MSTOP_A: rdata_nxt = mstop_a_r;
                OFS_MSTOP_B: rdata_nxt = mstop_b_r;
                OFS_MSTOP_C: rdata_nxt = mstop_c_r;
                OFS_MSTOP_D: rdata_nxt = mstop_d_r;
                OFS_OP_POWER: rdata_nxt[2:0] = op_mode_r;
                OFS_SUB_POWER: rdata_nxt[0] = sub_mode_r;
                OFS_OSC_WAIT: rdata_nxt[4:0] = osc_wait_r;
                OFS_RET_CLOCK: rdata_nxt[2:0] = ret_clock_r;
                OFS_PROTECT: rdata_nxt[3:0] = protect_r;
                OFS_STATUS: begin
                    rdata_nxt[4:0] = state_r;
                    rdata_nxt[5] = timer_busy;
                    rdata_nxt[7:6] = speed_r;
                end
                default: begin
                    // Software reset and unmapped words read as zero.
                end
            endcase
        end
    end

    // Register bank flip-flops.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            select_r <= 1'b0;
            out_en_r <= 1'b0;
            mstop_a_r <= RST_MSTOP;
            mstop_b_r <= RST_MSTOP;
            mstop_c_r <= RST_MSTOP;
            mstop_d_r <= RST_MSTOP;
            op_mode_r <= RST_OP_MODE;
            sub_mode_r <= 1'b0;
            osc_wait_r <= RST_OSC_WAIT;
            ret_clock_r <= RST_RET_CLOCK;
            protect_r <= RST_PROTECT;
            swrst_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            select_r <= select_nxt;
            out_en_r <= out_en_nxt;
            mstop_a_r <= mstop_a_nxt;
            mstop_b_r <= mstop_b_nxt;
            mstop_c_r <= mstop_c_nxt;
            mstop_d_r <= mstop_d_nxt;
            op_mode_r <= op_mode_nxt;
            sub_mode_r <= sub_mode_nxt;
            osc_wait_r <= osc_wait_nxt;
            ret_clock_r <= ret_clock_nxt;
            protect_r <= protect_nxt;
            swrst_r <= swrst_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Low power sequencer. Standby stops the main oscillator, so leaving it
    // waits out the stabilisation time before the core runs again.
    always_comb begin
        state_nxt = state_r;
        timer_load = 1'b0;
        timer_count = wait_cycles(osc_wait_r);
        case (state_r)
            LPWP_RUN: begin
                if (wait_exec_in) begin
                    if (select_r) begin
                        state_nxt = LPWP_STANDBY;
                    end else if (mstop_c_r[POS_DEEP_SLEEP]) begin
                        state_nxt = LPWP_DEEP;
                    end else begin
                        state_nxt = LPWP_SLEEP;
                    end
                end
            end
            LPWP_SLEEP, LPWP_DEEP: begin
                if (wake_in) begin
                    state_nxt = LPWP_RUN;
                end
            end
            LPWP_STANDBY: begin
                if (wake_in) begin
                    state_nxt = LPWP_OSC_WAIT;
                    timer_load = 1'b1;
                end
            end
            LPWP_OSC_WAIT: begin
                if (timer_done) begin
                    state_nxt = LPWP_RUN;
                end
            end
            default: begin
                state_nxt = LPWP_RUN;
            end
        endcase
    end

    // Registered bus mode outputs follow the next state, so they change on
    // the same edge as the state itself.
    always_comb begin
        float_nxt = (state_nxt == LPWP_STANDBY) && !out_en_r;
        hold_nxt = (state_nxt == LPWP_STANDBY) && out_en_r;
        if (sub_mode_r) begin
            speed_nxt = SPEED_LOW;
        end else if (op_mode_r == OPM_MIDDLE) begin
            speed_nxt = SPEED_MIDDLE;
        end else begin
            speed_nxt = SPEED_HIGH;
        end
    end

    // Sequencer flip-flops.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_r <= LPWP_RUN;
            float_r <= 1'b0;
            hold_r <= 1'b0;
            speed_r <= SPEED_HIGH;
        end else begin
            state_r <= state_nxt;
            float_r <= float_nxt;
            hold_r <= hold_nxt;
            speed_r <= speed_nxt;
        end
    end

    // Stabilisation timer.
    lpwp_wait_timer #(
        .WIDTH(WAIT_WIDTH)
    ) u_wait_timer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .load_in(timer_load),
        .count_in(timer_count),
        .busy_out(timer_busy),
        .done_out(timer_done)
    );

    // APB answer: always ready, error only on unmapped words.
    assign pready_out = 1'b1;
    assign pslverr_out = access && !mapped;
    assign prdata_out = rdata_r;

    // Status and control outputs.
    assign cpu_stop_out = (state_r != LPWP_RUN);
    assign sleep_out = (state_r == LPWP_SLEEP);
    assign deep_sleep_out = (state_r == LPWP_DEEP);
    assign standby_out = (state_r == LPWP_STANDBY);
    assign bus_float_out = float_r;
    assign bus_hold_out = hold_r;
    assign speed_out = speed_r;
    assign return_clock_out = ret_clock_r;
    assign module_stop_a_out = mstop_a_r;
    assign module_stop_b_out = mstop_b_r;
    assign module_stop_c_out = mstop_c_r;
    assign module_stop_d_out = mstop_d_r;
    assign clock_regs_write_ok_out = protect_r[0];
    assign mode_regs_write_ok_out = protect_r[1];
    assign low_power_timer_write_ok_out = protect_r[2];
    assign voltage_detect_write_ok_out = protect_r[3];
    assign software_reset_out = swrst_r;
endmodule

// ===== tb/lpwp_regs_sva.sv
// Purpose: Port-level checker for the low power and write protect register bank.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Bound into every instance of lpwp_regs below the module.
`timescale 1ns/1ps
module lpwp_regs_chk
    import lpwp_pkg::*;
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_in,
    // APB request.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    // Core event.
    input wire logic wait_exec_in,
    // Low power status.
    input wire logic sleep_out,
    input wire logic deep_sleep_out,
    input wire logic standby_out,
    input wire logic bus_float_out,
    input wire logic bus_hold_out,
    input wire logic [1:0] speed_out,
    input wire logic [31:0] module_stop_a_out,
    // Write permissions.
    input wire logic clock_regs_write_ok_out,
    input wire logic mode_regs_write_ok_out,
    input wire logic low_power_timer_write_ok_out,
    input wire logic voltage_detect_write_ok_out
);
    // A write lands at the access-phase edge, so every write check keys on it.
    wire logic wr_acc = psel_in & penable_in & pwrite_in;
    wire logic [3:0] prot_bits = pwdata_in[3:0];

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    property p_stby_entry;
        $rose(standby_out) |-> $past(wait_exec_in);
    endproperty
    a_stby_entry: assert property (p_stby_entry) else $error("standby without wait");

    property p_sleep_entry;
        $rose(sleep_out) || $rose(deep_sleep_out) |-> $past(wait_exec_in);
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep, no wait");

    property p_out_mode;
        standby_out |-> bus_float_out != bus_hold_out;
    endproperty
    a_out_mode: assert property (p_out_mode) else $error("bus mode not unique");

    property p_out_only_stby;
        bus_float_out || bus_hold_out |-> standby_out;
    endproperty
    a_out_only_stby: assert property (p_out_only_stby) else $error("bus mode outside");

    property p_refused;
        wr_acc && paddr_in == OFS_MSTOP_A && !mode_regs_write_ok_out
            |=> $stable(module_stop_a_out);
    endproperty
    a_refused: assert property (p_refused) else $error("protected write landed");

    property p_accepted;
        wr_acc && paddr_in == OFS_MSTOP_A && mode_regs_write_ok_out
            |=> module_stop_a_out == $past(pwdata_in);
    endproperty
    a_accepted: assert property (p_accepted) else $error("enabled write lost");

    property p_protect;
        wr_acc && paddr_in == OFS_PROTECT |=> {voltage_detect_write_ok_out,
            low_power_timer_write_ok_out, mode_regs_write_ok_out,
            clock_regs_write_ok_out} == $past(prot_bits);
    endproperty
    a_protect: assert property (p_protect) else $error("protect bits wrong");

    property p_sub_low;
        wr_acc && paddr_in == OFS_SUB_POWER && pwdata_in[0] && mode_regs_write_ok_out
            |-> ##[1:2] speed_out == SPEED_LOW;
    endproperty
    a_sub_low: assert property (p_sub_low) else $error("low speed not taken");
endmodule

bind lpwp_regs lpwp_regs_chk u_chk (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .wait_exec_in(wait_exec_in), .sleep_out(sleep_out),
    .deep_sleep_out(deep_sleep_out), .standby_out(standby_out),
    .bus_float_out(bus_float_out), .bus_hold_out(bus_hold_out), .speed_out(speed_out),
    .module_stop_a_out(module_stop_a_out), .clock_regs_write_ok_out(clock_regs_write_ok_out),
    .mode_regs_write_ok_out(mode_regs_write_ok_out),
    .low_power_timer_write_ok_out(low_power_timer_write_ok_out),
    .voltage_detect_write_ok_out(voltage_detect_write_ok_out));

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the low power and write protect register bank.
// Assumes: Zero wait state APB slave; long oscillator waits shortened by parameter.
// Notes: Bus results are queued as notes and compared by a monitor process.
`timescale 1ns/1ps
module tb_top
    import lpwp_pkg::*;
;
    logic clk_in = 1'b0, rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic wait_exec_in = 1'b0, wake_in = 1'b0, oe;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0, prdata_out, v, ms_a, ms_b, ms_c, ms_d;
    logic pready_out, pslverr_out, cpu_stop_out, sleep_out, deep_sleep_out, standby_out;
    logic bus_float_out, bus_hold_out, sw_rst, ok_clk, ok_mode, ok_lpt, ok_vd;
    logic [1:0] speed_out;
    logic [2:0] return_clock_out, m;
    // Note layout: [33] compare data, [32] expected error, [31:0] expected data.
    logic [33:0] notes[$];
    int errors = 0, cmp_count = 0, n;
    int waits[8] = '{2, 1024, 2048, 4096, 8, 9, 10, 11};
    integer seed = 32'he7a6cde0;

    // Small wait parameters keep the run short.
    lpwp_regs #(.WAIT_8192(8), .WAIT_16384(9), .WAIT_32768(10), .WAIT_65536(11)) uut (
        .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .wait_exec_in(wait_exec_in), .wake_in(wake_in), .cpu_stop_out(cpu_stop_out),
        .sleep_out(sleep_out), .deep_sleep_out(deep_sleep_out), .standby_out(standby_out),
        .bus_float_out(bus_float_out), .bus_hold_out(bus_hold_out), .speed_out(speed_out),
        .return_clock_out(return_clock_out), .module_stop_a_out(ms_a),
        .module_stop_b_out(ms_b), .module_stop_c_out(ms_c), .module_stop_d_out(ms_d),
        .clock_regs_write_ok_out(ok_clk), .mode_regs_write_ok_out(ok_mode),
        .low_power_timer_write_ok_out(ok_lpt), .voltage_detect_write_ok_out(ok_vd),
        .software_reset_out(sw_rst));

    // Clock of 40 MHz.
    always #12.5 clk_in = ~clk_in;

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; the request holds until pready is seen high.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] nt);
        notes.push_back(nt);
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 34'h0);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {2'b10, e});
    endtask

    // Pulse the wait instruction and let the edge land.
    task wait_cmd;
        @(posedge clk_in);
        wait_exec_in <= 1'b1;
        @(posedge clk_in);
        wait_exec_in <= 1'b0;
        #1;
    endtask

    // Pulse wake and count edges until the core runs.
    task wake_run(output int cnt);
        @(posedge clk_in);
        wake_in <= 1'b1;
        @(posedge clk_in);
        wake_in <= 1'b0;
        cnt = 0;
        while (cpu_stop_out !== 1'b0 && cnt < 70000) begin
            @(posedge clk_in);
            cnt++;
        end
    endtask

    // Monitor: the answer is taken at the access edge and matched to the oldest note.
    always @(posedge clk_in) begin
        if (psel_in && penable_in && pready_out === 1'b1) begin
            chk("pslverr", {31'h0, notes[0][32]}, {31'h0, pslverr_out});
            if (notes[0][33]) chk("prdata", notes[0][31:0], prdata_out);
            void'(notes.pop_front());
        end
    end

    task give_verdict;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Watchdog sized well above the sum of all oscillator waits.
    initial begin
        repeat (60000) @(posedge clk_in);
        errors++;
        give_verdict;
    end

    initial begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int i = 1; i < 5; i++) rd(8'(4 * i), RST_MSTOP);
        rd(OFS_STATUS, 32'h1);
        wr(OFS_MSTOP_A, 32'h0);
        rd(OFS_MSTOP_A, RST_MSTOP);
        apb(1'b0, 8'h30, 32'h0, {2'b11, 32'h0});
        // Each protect bit alone must open only its own group.
        for (int b = 0; b < 4; b++) begin
            wr(OFS_PROTECT, 32'h1 << b);
            #1;
            chk("perm", 32'h1 << b, {28'h0, ok_vd, ok_lpt, ok_mode, ok_clk});
        end
        wr(OFS_PROTECT, 32'hf);
        wr(OFS_SW_RESET, 32'h0);
        #1 chk("sw_rst", 32'h1, {31'h0, sw_rst});
        for (int i = 1; i < 5; i++) begin
            v = $random(seed);
            wr(8'(4 * i), v);
            rd(8'(4 * i), v);
        end
        chk("stop_d", v, ms_d);
        for (int c = 0; c < 8; c++) begin
            wr(OFS_OP_POWER, 32'(c));
            if (c == 0 || c == 2) m = 3'(c);
            rd(OFS_OP_POWER, {29'h0, m});
        end
        rd(OFS_STATUS, 32'h41);
        wr(OFS_SUB_POWER, 32'h1);
        rd(OFS_STATUS, 32'h81);
        wr(OFS_SUB_POWER, 32'h0);
        rd(OFS_STATUS, 32'h41);
        for (int c = 0; c < 8; c++) begin
            wr(OFS_RET_CLOCK, 32'(c));
            if (c < 3) m = 3'(c);
            rd(OFS_RET_CLOCK, {29'h0, m});
            chk("ret_clk", {29'h0, m}, {29'h0, return_clock_out});
        end
        // Every wait code, each time through standby with a random bus mode.
        for (int c = 0; c < 8; c++) begin
            wr(OFS_OSC_WAIT, 32'(c));
            oe = $random(seed);
            wr(OFS_STANDBY, {16'h0, 1'b1, oe, 14'h0});
            wait_cmd;
            chk("stby", {29'h0, oe, ~oe, 1'b1},
                {29'h0, bus_hold_out, bus_float_out, standby_out});
            wake_run(n);
            chk("osc_wait", 32'h1, 32'(n >= waits[c] && n <= waits[c] + 4));
        end
        wr(OFS_OSC_WAIT, 32'h8);
        rd(OFS_OSC_WAIT, 32'h7);
        for (int d = 0; d < 2; d++) begin
            wr(OFS_STANDBY, 32'h0);
            wr(OFS_MSTOP_C, {1'(d), 31'h0});
            wait_cmd;
            chk("sleep", {29'h0, 1'b0, 1'(d), ~1'(d)},
                {29'h0, standby_out, deep_sleep_out, sleep_out});
            wake_run(n);
            chk("woke", 32'h1, 32'(n <= 4));
        end
        // With protection closed again nothing may change.
        wr(OFS_PROTECT, 32'h0);
        wr(OFS_RET_CLOCK, 32'h1);
        rd(OFS_RET_CLOCK, 32'h2);
        wr(OFS_STANDBY, 32'h8000);
        rd(OFS_STANDBY, 32'h0);
        give_verdict;
    end
endmodule
